// File: tcd_pkg.sv
package tcd_pkg;
    // Register map on the plain port
    localparam logic [3:0] TCD_REG_CTRL     = 4'h0;
    localparam logic [3:0] TCD_REG_DEB_LEN  = 4'h1;
    localparam logic [3:0] TCD_REG_PRESCALE = 4'h2;
    localparam logic [3:0] TCD_REG_DEV_KEY  = 4'h3;
    localparam logic [3:0] TCD_REG_GRP_KEY  = 4'h4;
    localparam logic [3:0] TCD_REG_GRP_MASK = 4'h5;
    localparam logic [3:0] TCD_REG_ACT_SEL  = 4'h6;
    localparam logic [3:0] TCD_REG_STATUS   = 4'h7;
    localparam logic [3:0] TCD_REG_COUNTS   = 4'h8;

    // Control fields
    localparam int TCD_CTRL_DEB_EN  = 0;
    localparam int TCD_CTRL_SRC_LSB = 1;
    localparam int TCD_CTRL_SRC_W   = 2;
    localparam int TCD_CTRL_ACT_EN  = 3;

    // Reset values
    localparam logic [31:0] TCD_DEB_LEN_RST  = 32'h0000_0000;
    localparam logic [3:0]  TCD_PRESCALE_RST = 4'h0;

    // Timing: system clock period and trigger release budget
    localparam int TCD_CLK_PERIOD_NS = 10;
    localparam int TCD_DEB_UNIT_NS   = 15;
    localparam int TCD_ACT_MAX_NS    = 50130;
    localparam int TCD_ACT_MAX_CYC   = TCD_ACT_MAX_NS / TCD_CLK_PERIOD_NS;

    // Action packet layout
    localparam logic [7:0]  TCD_PKT_KEY     = 8'h42;
    localparam logic [15:0] TCD_PKT_CMD     = 16'h0100;
    localparam logic [15:0] TCD_PKT_LEN     = 16'h000c;
    localparam logic [7:0]  TCD_FLAG_ACK    = 8'h01;
    localparam logic [7:0]  TCD_FLAG_NOACK  = 8'h00;
    localparam logic [15:0] TCD_UDP_PORT    = 16'h0f74;
    localparam int          TCD_PKT_BYTES   = 20;
    localparam int          TCD_OFS_FLAG    = 1;
    localparam int          TCD_OFS_CMD     = 2;
    localparam int          TCD_OFS_LEN     = 4;
    localparam int          TCD_OFS_REQ     = 6;
    localparam int          TCD_OFS_DKEY    = 8;
    localparam int          TCD_OFS_GKEY    = 12;
    localparam int          TCD_OFS_GMASK   = 16;

    typedef enum logic [1:0] {
        TCD_PS_IDLE  = 2'b00,
        TCD_PS_RECV  = 2'b01,
        TCD_PS_CHECK = 2'b11,
        TCD_PS_DROP  = 2'b10
    } tcd_parse_state_type;
endpackage

// File: tcd_debounce.sv
`timescale 1ns/1ps
module tcd_debounce
    import tcd_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             raw_trigger_in,
    input  wire logic [CNT_W-1:0] debounce_length,
    output logic                  pulse_out
);
    typedef struct packed {
        logic             level;
        logic [CNT_W-1:0] count;
    } tcd_deb_st_type;

    tcd_deb_st_type st_q;
    tcd_deb_st_type st_d;

    always_comb begin
        st_d = st_q;
        if (raw_trigger_in == st_q.level) begin
            st_d.count = '0;
        end else if (st_q.count + 1'b1 >= debounce_length) begin
            st_d.level = raw_trigger_in;
            st_d.count = '0;
        end else begin
            st_d.count = st_q.count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse_out = st_q.level;
endmodule

// File: tcd_prescale.sv
`timescale 1ns/1ps
module tcd_prescale
    import tcd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       trig_in,
    input  wire logic [3:0] divisor,
    output logic            trig_out
);
    typedef struct packed {
        logic       prev;
        logic [3:0] count;
        logic [3:0] div_seen;
        logic       out;
    } tcd_ps_st_type;

    tcd_ps_st_type st_q;
    tcd_ps_st_type st_d;

    always_comb begin
        st_d          = st_q;
        st_d.prev     = trig_in;
        st_d.div_seen = divisor;
        st_d.out      = 1'b0;
        if (divisor != st_q.div_seen) begin
            st_d.count = '0;
        end else if (trig_in && !st_q.prev) begin
            // Divisor code n divides by n+1, so code 15 divides by 16
            if (st_q.count == 4'h0) begin
                st_d.out = 1'b1;
            end
            st_d.count = (st_q.count >= divisor) ? 4'h0 : st_q.count + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign trig_out = st_q.out;
endmodule

// File: tcd_top.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module tcd_top
    import tcd_pkg::*;
#(
    parameter int LINES = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic [LINES-1:0] line_in,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    input  wire logic             pkt_valid,
    input  wire logic [7:0]       pkt_data,
    input  wire logic             pkt_first,
    input  wire logic             pkt_last,
    input  wire logic [15:0]      pkt_dst_port,
    input  wire logic             pkt_broadcast,
    output logic                  line_trigger,
    output logic                  action_trigger,
    output logic                  ack_request,
    output logic      [15:0]      ack_req_id
);
    typedef struct packed {
        logic [LINES-1:0]    sync1;
        logic [LINES-1:0]    sync2;
        logic                deb_en;
        logic [1:0]          src_sel;
        logic                act_en;
        logic [31:0]         deb_len;
        logic [3:0]          prescale;
        logic [31:0]         dev_key;
        logic [31:0]         grp_key;
        logic [31:0]         grp_mask;
        logic [31:0]         act_sel;
        logic [31:0]         rdata;
        tcd_parse_state_type ps;
        logic [4:0]          idx;
        logic                port_ok;
        logic                bcast;
        logic [7:0]          flag;
        logic [15:0]         cmd;
        logic [15:0]         len;
        logic [15:0]         req_id;
        logic [31:0]         p_dkey;
        logic [31:0]         p_gkey;
        logic [31:0]         p_gmask;
        logic                act_trig;
        logic                ack_req;
        logic [15:0]         ack_id;
        logic                last_bcast;
        logic [15:0]         n_fired;
        logic [15:0]         n_dropped;
    } tcd_top_st_type;

    tcd_top_st_type st_q;
    tcd_top_st_type st_d;

    logic sel_line;
    logic deb_line;
    logic pre_in;
    logic pre_out;

    assign sel_line = st_q.sync2[st_q.src_sel];

    tcd_debounce #(
        .CNT_W(32)
    ) u_deb (
        .clk_sys        (clk_sys),
        .srst           (srst),
        .raw_trigger_in (sel_line),
        .debounce_length(st_q.deb_len),
        .pulse_out      (deb_line)
    );

    assign pre_in = st_q.deb_en ? deb_line : sel_line;

    tcd_prescale u_pre (
        .clk_sys (clk_sys),
        .srst    (srst),
        .trig_in (pre_in),
        .divisor (st_q.prescale),
        .trig_out(pre_out)
    );

    always_comb begin
        st_d          = st_q;
        st_d.sync1    = line_in;
        st_d.sync2    = st_q.sync1;
        st_d.rdata    = st_q.rdata;
        st_d.act_trig = 1'b0;
        st_d.ack_req  = 1'b0;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                TCD_REG_CTRL: begin
                    st_d.deb_en  = reg_wdata[TCD_CTRL_DEB_EN];
                    st_d.src_sel = reg_wdata[TCD_CTRL_SRC_LSB +: TCD_CTRL_SRC_W];
                    st_d.act_en  = reg_wdata[TCD_CTRL_ACT_EN];
                end
                TCD_REG_DEB_LEN:  st_d.deb_len  = reg_wdata;
                TCD_REG_PRESCALE: st_d.prescale = reg_wdata[3:0];
                TCD_REG_DEV_KEY:  st_d.dev_key  = reg_wdata;
                TCD_REG_GRP_KEY:  st_d.grp_key  = reg_wdata;
                TCD_REG_GRP_MASK: st_d.grp_mask = reg_wdata;
                TCD_REG_ACT_SEL:  st_d.act_sel  = reg_wdata;
                default: begin
                end
            endcase
        end

        // Register reads, data valid the cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                TCD_REG_CTRL: st_d.rdata = {28'h0, st_q.act_en, st_q.src_sel, st_q.deb_en};
                TCD_REG_DEB_LEN:  st_d.rdata = st_q.deb_len;
                TCD_REG_PRESCALE: st_d.rdata = {28'h0, st_q.prescale};
                TCD_REG_DEV_KEY:  st_d.rdata = st_q.dev_key;
                TCD_REG_GRP_KEY:  st_d.rdata = st_q.grp_key;
                TCD_REG_GRP_MASK: st_d.rdata = st_q.grp_mask;
                TCD_REG_ACT_SEL:  st_d.rdata = st_q.act_sel;
                TCD_REG_STATUS: begin
                    st_d.rdata = {27'h0, st_q.last_bcast, pre_out, deb_line,
                                  sel_line, st_q.ps == TCD_PS_RECV};
                end
                TCD_REG_COUNTS:   st_d.rdata = {st_q.n_dropped, st_q.n_fired};
                default:          st_d.rdata = 32'h0000_0000;
            endcase
        end else begin
            st_d.rdata = 32'h0000_0000;
        end

        // Action packet parser, bytes in network order
        case (st_q.ps)
            TCD_PS_IDLE: begin
                if (pkt_valid && pkt_first) begin
                    st_d.idx     = 5'd1;
                    st_d.port_ok = (pkt_dst_port == TCD_UDP_PORT);
                    st_d.bcast   = pkt_broadcast;
                    st_d.ps      = (pkt_data == TCD_PKT_KEY && !pkt_last)
                                   ? TCD_PS_RECV : TCD_PS_DROP;
                    if (pkt_data != TCD_PKT_KEY || pkt_last) begin
                        st_d.ps = pkt_last ? TCD_PS_IDLE : TCD_PS_DROP;
                    end
                end
            end
            TCD_PS_RECV: begin
                if (pkt_valid) begin
                    st_d.idx = st_q.idx + 5'd1;
                    if (st_q.idx == 5'(TCD_OFS_FLAG)) begin
                        st_d.flag = pkt_data;
                    end else if (st_q.idx < 5'(TCD_OFS_LEN)) begin
                        st_d.cmd = {st_q.cmd[7:0], pkt_data};
                    end else if (st_q.idx < 5'(TCD_OFS_REQ)) begin
                        st_d.len = {st_q.len[7:0], pkt_data};
                    end else if (st_q.idx < 5'(TCD_OFS_DKEY)) begin
                        st_d.req_id = {st_q.req_id[7:0], pkt_data};
                    end else if (st_q.idx < 5'(TCD_OFS_GKEY)) begin
                        st_d.p_dkey = {st_q.p_dkey[23:0], pkt_data};
                    end else if (st_q.idx < 5'(TCD_OFS_GMASK)) begin
                        st_d.p_gkey = {st_q.p_gkey[23:0], pkt_data};
                    end else begin
                        st_d.p_gmask = {st_q.p_gmask[23:0], pkt_data};
                    end
                    if (st_q.idx == 5'(TCD_PKT_BYTES - 1)) begin
                        st_d.ps = TCD_PS_CHECK;
                    end else if (pkt_last) begin
                        st_d.ps        = TCD_PS_IDLE;
                        st_d.n_dropped = st_q.n_dropped + 16'h1;
                    end
                end
            end
            TCD_PS_CHECK: begin
                st_d.ps = TCD_PS_IDLE;
                // Unicast or broadcast, same check
                if (st_q.act_en && st_q.port_ok
                    && st_q.cmd == TCD_PKT_CMD && st_q.len == TCD_PKT_LEN
                    && st_q.p_dkey == st_q.dev_key
                    && st_q.p_gkey == st_q.grp_key
                    && (st_q.p_gmask & st_q.grp_mask) != 32'h0) begin
                    st_d.act_trig   = 1'b1;
                    st_d.ack_req    = (st_q.flag == TCD_FLAG_ACK);
                    st_d.ack_id     = st_q.req_id;
                    st_d.last_bcast = st_q.bcast;
                    st_d.n_fired    = st_q.n_fired + 16'h1;
                end else begin
                    st_d.n_dropped  = st_q.n_dropped + 16'h1;
                end
            end
            TCD_PS_DROP: begin
                if (pkt_valid && pkt_last) begin
                    st_d.ps        = TCD_PS_IDLE;
                    st_d.n_dropped = st_q.n_dropped + 16'h1;
                end
            end
            default: st_d.ps = TCD_PS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q          <= '0;
            st_q.deb_len  <= TCD_DEB_LEN_RST;
            st_q.prescale <= TCD_PRESCALE_RST;
            st_q.ps       <= TCD_PS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata      = st_q.rdata;
    assign line_trigger   = pre_out;
    assign action_trigger = st_q.act_trig;
    assign ack_request    = st_q.ack_req;
    assign ack_req_id     = st_q.ack_id;
endmodule

// File: tcd_top_assertions.sv
`timescale 1ns/1ps
module tcd_top_assertions
    import tcd_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        pkt_valid,
    input wire logic        pkt_last,
    input wire logic [15:0] pkt_dst_port,
    input wire logic        line_trigger,
    input wire logic        action_trigger,
    input wire logic        ack_request,
    input wire logic [15:0] ack_req_id
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Last byte of a packet aimed at the control port
    sequence pkt_end;
        pkt_valid && pkt_last && pkt_dst_port == TCD_UDP_PORT;
    endsequence
    // Read of an index above the map
    sequence rd_unmapped;
        reg_rd && reg_addr > TCD_REG_COUNTS;
    endsequence
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    rd_hole_a: assert property (rd_unmapped |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    rd_divisor_a: assert property (
        reg_rd && reg_addr == TCD_REG_PRESCALE |=> reg_rdata[31:4] == 28'h0)
        else $error("divisor wider than four bits");
    line_pulse_a: assert property (line_trigger |=> !line_trigger)
        else $error("line trigger longer than one cycle");
    act_delay_a: assert property (
        action_trigger |-> $past(pkt_valid && pkt_last, 2)
                           && $past(pkt_dst_port, 2) == TCD_UDP_PORT)
        else $error("action trigger without packet end two cycles before");
    act_early_a: assert property (pkt_end |=> !action_trigger)
        else $error("action trigger one cycle after packet end");
    act_pulse_a: assert property (action_trigger |=> !action_trigger)
        else $error("action trigger longer than one cycle");
    ack_pair_a: assert property (ack_request |-> action_trigger)
        else $error("acknowledge request without trigger");
    ackid_hold_a: assert property (
        !action_trigger && !$past(action_trigger) |-> $stable(ack_req_id))
        else $error("request id changed without a match");
endmodule

bind tcd_top tcd_top_assertions u_chk (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_last(pkt_last),
    .pkt_dst_port(pkt_dst_port), .line_trigger(line_trigger),
    .action_trigger(action_trigger), .ack_request(ack_request), .ack_req_id(ack_req_id)
);

// File: tcd_host_model.sv
`timescale 1ns/1ps
module tcd_host_model
    import tcd_pkg::*;
(
    input  wire logic   clk_sys,
    output logic [3:0]  line_in,
    output logic        pkt_valid,
    output logic [7:0]  pkt_data,
    output logic        pkt_first,
    output logic        pkt_last,
    output logic [15:0] pkt_dst_port,
    output logic        pkt_broadcast
);
    initial begin
        line_in = 4'h0;
        pkt_valid = 1'b0;
        pkt_data = 8'h00;
        pkt_first = 1'b0;
        pkt_last = 1'b0;
        pkt_dst_port = 16'h0;
        pkt_broadcast = 1'b0;
    end
    // One trigger pulse on a line, then a low gap
    task automatic pulse(input int ln, hi, lo);
        line_in[ln] <= 1'b1;
        repeat (hi) @(posedge clk_sys);
        line_in[ln] <= 1'b0;
        repeat (lo) @(posedge clk_sys);
    endtask
    // Action packet, big endian, n bytes of it, then one idle cycle
    task automatic send(input logic [7:0] key, flag, input logic [15:0] cmd, req,
                        input logic [31:0] dk, gk, gm, input logic [15:0] port,
                        input logic bc, input int n);
        logic [159:0] b;
        b = {key, flag, cmd, TCD_PKT_LEN, req, dk, gk, gm};
        for (int i = 0; i < n; i++) begin
            pkt_valid <= 1'b1;
            pkt_data <= b[159-8*i -: 8];
            pkt_first <= i == 0;
            pkt_last <= i == n - 1;
            pkt_dst_port <= port;
            pkt_broadcast <= bc;
            @(posedge clk_sys);
        end
        pkt_valid <= 1'b0;
        pkt_last <= 1'b0;
        pkt_data <= ~pkt_data;
        @(posedge clk_sys);
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import tcd_pkg::*;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, v;
    logic [3:0]  line_in;
    logic [7:0]  pkt_data;
    logic [15:0] pkt_dst_port, ack_req_id;
    logic        pkt_valid, pkt_first, pkt_last, pkt_broadcast;
    logic        line_trigger, action_trigger, ack_request;
    bit          act_on;
    int          fails, checked, n_line, n_act, n_ack, n_drop, n_fire, k;
    int          seed = 24554;
    logic [15:0] exp_id[$];
    int          dv[3] = '{0, 2, 15};
    always #5 clk_sys = ~clk_sys;
    tcd_top uut (.clk_sys(clk_sys), .srst(srst), .line_in(line_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_first(pkt_first),
        .pkt_last(pkt_last), .pkt_dst_port(pkt_dst_port), .pkt_broadcast(pkt_broadcast),
        .line_trigger(line_trigger), .action_trigger(action_trigger),
        .ack_request(ack_request), .ack_req_id(ack_req_id));
    tcd_host_model host (.clk_sys(clk_sys), .line_in(line_in), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .pkt_first(pkt_first), .pkt_last(pkt_last),
        .pkt_dst_port(pkt_dst_port), .pkt_broadcast(pkt_broadcast));
    always @(posedge clk_sys) begin
        n_line += (line_trigger === 1'b1);
        n_act += (action_trigger === 1'b1);
        n_ack += (ack_request === 1'b1);
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check("reg", reg_rdata, exp);
        @(posedge clk_sys);
    endtask
    task automatic pulses(input int ln, hi, cnt);
        repeat (cnt) host.pulse(ln, hi, 10);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic pkt(input logic [7:0] key, flag, input logic [15:0] cmd,
                       input logic [31:0] dk, gk, gm, input logic [15:0] port, input int n);
        bit fire;
        int a0, k0;
        fire = act_on && key == 8'h42 && cmd == 16'h0100 && port == 16'd3956 && n == 20
            && dk == 32'haffe && gk == 32'h1234 && (gm & 32'h3) != 0;
        a0 = n_act;
        k0 = n_ack;
        v = $random(seed);
        host.send(key, flag, cmd, v[15:0], dk, gk, gm, port, v[16], n);
        repeat (4) @(posedge clk_sys);
        n_drop += !fire;
        n_fire += fire;
        check("fire", n_act - a0, fire);
        check("ack", n_ack - k0, fire && flag == 8'h01);
        if (fire) exp_id.push_back(v[15:0]);
        if (exp_id.size() > 0) check("req_id", ack_req_id, exp_id[$]);
        if (fire) rd(TCD_REG_STATUS, {27'h0, v[16], 4'h0});
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        for (int a = 0; a < 16; a++) rd(a[3:0], 32'h0);
        for (int a = 3; a < 7; a++) begin
            v = $random(seed);
            wr(a[3:0], v);
            rd(a[3:0], v);
        end
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h0);
        wr(TCD_REG_PRESCALE, 32'hffff_fff5);
        rd(TCD_REG_PRESCALE, 32'h5);
        wr(TCD_REG_CTRL, 32'h0);
        foreach (dv[i]) begin
            wr(TCD_REG_PRESCALE, dv[i]);
            k = 1 + {$random(seed)} % 20;
            v = n_line;
            pulses(0, 3, k);
            check("divide", n_line - v, (k + dv[i]) / (dv[i] + 1));
            wr(TCD_REG_PRESCALE, dv[i] ^ 1);
            wr(TCD_REG_PRESCALE, dv[i]);
            pulses(0, 3, 1);
            check("restart", n_line - v, (k + dv[i]) / (dv[i] + 1) + 1);
        end
        wr(TCD_REG_PRESCALE, 32'h0);
        wr(TCD_REG_CTRL, 32'h4);
        v = n_line;
        pulses(0, 3, 2);
        check("select", n_line - v, 0);
        wr(TCD_REG_DEB_LEN, 32'h6);
        wr(TCD_REG_CTRL, 32'h5);
        pulses(2, 4, 1);
        check("glitch", n_line - v, 0);
        pulses(2, 8, 1);
        check("debounce", n_line - v, 1);
        wr(TCD_REG_DEV_KEY, 32'haffe);
        wr(TCD_REG_GRP_KEY, 32'h1234);
        wr(TCD_REG_GRP_MASK, 32'h3);
        wr(TCD_REG_CTRL, 32'h8);
        act_on = 1'b1;
        pkt(8'h42, 8'h01, 16'h0100, 32'haffe, 32'h1234, 32'h2, 16'd3956, 20);
        pkt(8'h42, 8'h00, 16'h0100, 32'haffe, 32'h1234, 32'h7fff_ffff, 16'd3956, 20);
        pkt(8'h42, 8'h01, 16'h0100, 32'haffe, 32'h1234, 32'hc, 16'd3956, 20);
        pkt(8'h42, 8'h01, 16'h0100, 32'haffd, 32'h1234, 32'h1, 16'd3956, 20);
        pkt(8'h42, 8'h01, 16'h0100, 32'haffe, 32'h1, 32'h1, 16'd3956, 20);
        pkt(8'h42, 8'h01, 16'h0101, 32'haffe, 32'h1234, 32'h1, 16'd3956, 20);
        pkt(8'h42, 8'h01, 16'h0100, 32'haffe, 32'h1234, 32'h1, 16'd3957, 20);
        pkt(8'h43, 8'h01, 16'h0100, 32'haffe, 32'h1234, 32'h1, 16'd3956, 20);
        pkt(8'h42, 8'h01, 16'h0100, 32'haffe, 32'h1234, 32'h1, 16'd3956, 12);
        wr(TCD_REG_CTRL, 32'h0);
        act_on = 1'b0;
        pkt(8'h42, 8'h01, 16'h0100, 32'haffe, 32'h1234, 32'h1, 16'd3956, 20);
        rd(TCD_REG_COUNTS, {n_drop[15:0], n_fire[15:0]});
        summarize;
    end
endmodule
